/* cgp_clock_power.sv */
// Clock generation, oscillator supervisor and power management top
`timescale 1ns/1ns
`include "cgp_defs.svh"

module cgp_clock_power import cgp_pkg::*; #(
  parameter int NUM_PERIPH = 8,
  parameter int PLL_FREE_DIV = `CGP_PLL_FREE_DIV,
  parameter int OSC_MISS_LIMIT = `CGP_OSC_MISS_LIMIT
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // Register port
  input wire cgp_bus_req_type BUS_I,
  output logic [15:0] RDATA_O,
  // Pins and straps
  input wire logic OSC_PIN_I,
  input wire logic EXT_ACCESS_SELECT_N_I,
  input wire logic READ_STROBE_N_I,
  // Power mode instructions and wake sources
  input wire cgp_instr_type INSTR_I,
  input wire logic EXT_IRQ_I,
  input wire logic RTC_WAKE_I,
  // Peripheral activity
  input wire logic [NUM_PERIPH-1:0] PERIPH_ACTIVE_I,
  // Clock enables and clock outputs
  output logic MASTER_TICK_O,
  output logic CAN_TICK_O,
  output logic MASTER_CLOCK_O,
  output logic SYS_TICK_O,
  output logic CPU_TICK_O,
  output logic [NUM_PERIPH-1:0] PERIPH_TICK_O,
  output logic RTC_TICK_O,
  output logic FREQ_OUT_O,
  // Status
  output logic EMERGENCY_O,
  output logic IRQ_O
);

  // =====================================================================
  // Elaboration checks
  initial begin
    if (NUM_PERIPH < 1 || NUM_PERIPH > 16) $error("NUM_PERIPH must be 1..16");
    if (PLL_FREE_DIV < 8 || PLL_FREE_DIV > 256) $error("PLL_FREE_DIV must be 8..256");
    if (OSC_MISS_LIMIT < 1 || OSC_MISS_LIMIT > 255) $error("OSC_MISS_LIMIT must be 1..255");
  end

  localparam logic [7:0] FREE_LAST = 8'(PLL_FREE_DIV - 1);
  localparam logic [7:0] MISS_LIM = 8'(OSC_MISS_LIMIT);

  // =====================================================================
  // Registers and register port
  cgp_clk_ctrl_type ctrl_q;
  logic [15:0] pdis_q;
  logic [15:0] programmable_freq_output_div_q;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_en_q;
  logic rtc_keep_q;
  cgp_pwr_type pwr_q, pwr_d;

  // Address decode
  wire wr_ctrl = BUS_I.wr && BUS_I.addr == `CGP_OFF_CLK_CTRL;
  wire wr_pdis = BUS_I.wr && BUS_I.addr == `CGP_OFF_PERIPH_DIS;
  wire wr_programmable_freq_output = BUS_I.wr && BUS_I.addr == `CGP_OFF_PROGRAMMABLE_FREQ_OUTPUT_DIV;
  wire wr_clr = BUS_I.wr && BUS_I.addr == `CGP_OFF_IRQ_CLEAR;
  wire wr_en = BUS_I.wr && BUS_I.addr == `CGP_OFF_IRQ_ENABLE;
  wire wr_pwr = BUS_I.wr && BUS_I.addr == `CGP_OFF_PWR_CTRL;

  // Plain register writes; power modes have no register path
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      ctrl_q <= `CGP_RST_CLK_CTRL;
      pdis_q <= `CGP_RST_PERIPH_DIS;
      programmable_freq_output_div_q <= `CGP_RST_PROGRAMMABLE_FREQ_OUTPUT_DIV;
      irq_en_q <= `CGP_RST_IRQ_ENABLE;
      rtc_keep_q <= `CGP_RST_PWR_CTRL;
    end else begin
      if (wr_ctrl) ctrl_q <= BUS_I.wdata;
      if (wr_pdis) pdis_q <= BUS_I.wdata;
      if (wr_programmable_freq_output) programmable_freq_output_div_q <= BUS_I.wdata;
      if (wr_en) irq_en_q <= BUS_I.wdata[1:0];
      if (wr_pwr) rtc_keep_q <= BUS_I.wdata[`CGP_PWR_RTC_KEEP];
    end
  end

  // =====================================================================
  // Reset-time strap for the supervisor
  logic strap_done_q;
  logic sup_strap_off_q;

  // Caught in the first cycle after release, never inside the reset branch
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      strap_done_q <= 1'b0;
      sup_strap_off_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      sup_strap_off_q <= !EXT_ACCESS_SELECT_N_I && !READ_STROBE_N_I;
    end
  end

  // =====================================================================
  // Free running PLL and multiplied PLL tick
  logic [7:0] free_cnt_q;
  logic [7:0] fast_cnt_q;
  wire pll_on = ctrl_q.pll_on;
  wire free_tick = pll_on && free_cnt_q == FREE_LAST;
  wire [7:0] fast_last = FREE_LAST >> ctrl_q.mult;
  wire fast_tick = pll_on && fast_cnt_q >= fast_last;

  // PLL counters keep running whatever the master source is
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || !pll_on) begin
      free_cnt_q <= 8'h00;
      fast_cnt_q <= 8'h00;
    end else begin
      free_cnt_q <= free_tick ? 8'h00 : free_cnt_q + 8'h01;
      fast_cnt_q <= fast_tick ? 8'h00 : fast_cnt_q + 8'h01;
    end
  end

  // =====================================================================
  // Oscillator edge and prescaler
  logic osc_q;
  logic [3:0] presc_cnt_q;
  wire osc_edge = OSC_PIN_I && !osc_q;
  wire presc_tick = osc_edge && presc_cnt_q == ctrl_q.presc;

  // Prescaler divides oscillator edges by presc plus one
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      osc_q <= OSC_PIN_I; // Pin level at release, so a high pin is no false edge
      presc_cnt_q <= 4'h0;
    end else begin
      osc_q <= OSC_PIN_I;
      if (osc_edge) presc_cnt_q <= presc_tick ? 4'h0 : presc_cnt_q + 4'h1;
    end
  end

  // =====================================================================
  // Oscillator supervisor
  logic [7:0] miss_cnt_q;
  logic emerg_q;
  wire sup_en = pll_on && !sup_strap_off_q;
  wire osc_fail = sup_en && free_tick && miss_cnt_q == MISS_LIM - 8'h01;
  wire clr_fail = wr_clr && BUS_I.wdata[`CGP_IRQ_OSC_FAIL];

  // Counts PLL basic ticks without an oscillator edge
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || !sup_en || osc_edge) begin
      miss_cnt_q <= 8'h00;
    end else if (free_tick && miss_cnt_q != MISS_LIM) begin
      miss_cnt_q <= miss_cnt_q + 8'h01;
    end
  end

  // Emergency latches on a PLL tick, so the old source is dropped on a boundary
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      emerg_q <= 1'b0;
    end else if (osc_fail) begin
      emerg_q <= 1'b1;
    end else if (!pll_on || (clr_fail && miss_cnt_q != MISS_LIM)) begin
      emerg_q <= 1'b0;
    end
  end

  // =====================================================================
  // Master clock source selection
  logic src_tick;

  // Emergency overrides the programmed source with the basic PLL rate
  always_comb begin
    src_tick = 1'b0;
    if (emerg_q) begin
      src_tick = free_tick;
    end else begin
      case (ctrl_q.src)
        CGP_SRC_PLL: src_tick = fast_tick;
        CGP_SRC_DIRECT: src_tick = osc_edge;
        CGP_SRC_PRESC: src_tick = presc_tick;
        default: src_tick = 1'b0;
      endcase
    end
  end

  // A fail cycle blanks the old source; the next tick is a full PLL period away
  wire clocks_stop = pwr_q == CGP_SLEEP || pwr_q == CGP_PWRDN;
  wire mc_tick = src_tick && !osc_fail && !clocks_stop;

  // =====================================================================
  // System and CPU clock derivation
  logic half_ph_q;
  logic [3:0] slow_cnt_q;
  wire sys_pre = mc_tick && (!ctrl_q.half || half_ph_q);
  wire sys_tick = sys_pre && slow_cnt_q == ctrl_q.cpu_slow;

  // Two to one phase and software slowdown counter
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      half_ph_q <= 1'b0;
      slow_cnt_q <= 4'h0;
    end else begin
      if (mc_tick) half_ph_q <= !half_ph_q;
      if (sys_pre) slow_cnt_q <= sys_tick ? 4'h0 : slow_cnt_q + 4'h1;
    end
  end

  // =====================================================================
  // Frequency output divider
  logic [15:0] programmable_freq_output_cnt_q;
  logic programmable_freq_output_q;
  wire programmable_freq_output_hit = mc_tick && programmable_freq_output_cnt_q == programmable_freq_output_div_q;

  // Toggles every programmable_freq_output_div plus one master ticks
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      programmable_freq_output_cnt_q <= 16'h0000;
      programmable_freq_output_q <= 1'b0;
    end else if (mc_tick) begin
      programmable_freq_output_cnt_q <= programmable_freq_output_hit ? 16'h0000 : programmable_freq_output_cnt_q + 16'h0001;
      if (programmable_freq_output_hit) programmable_freq_output_q <= !programmable_freq_output_q;
    end
  end

  // =====================================================================
  // Power state machine
  wire wake_sleep = EXT_IRQ_I || RTC_WAKE_I;

  // Only instruction strobes enter a saving mode
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      CGP_RUN: begin
        if (INSTR_I.pwrdn) pwr_d = CGP_PWRDN;
        else if (INSTR_I.sleep) pwr_d = CGP_SLEEP;
        else if (INSTR_I.idle) pwr_d = CGP_IDLE;
      end
      CGP_IDLE: begin
        if (EXT_IRQ_I || IRQ_O) pwr_d = CGP_RUN;
      end
      CGP_SLEEP: begin
        if (wake_sleep) pwr_d = CGP_RUN;
      end
      CGP_PWRDN: pwr_d = CGP_PWRDN;
      default: pwr_d = CGP_RUN;
    endcase
  end

  // Power-down leaves through reset only
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) pwr_q <= CGP_RUN;
    else pwr_q <= pwr_d;
  end

  // =====================================================================
  // Interrupt status
  wire wake_evt = pwr_q == CGP_SLEEP && wake_sleep;
  wire [1:0] irq_set = {wake_evt, osc_fail};
  wire [1:0] irq_clr = wr_clr ? BUS_I.wdata[1:0] : 2'h0;

  // Set beats clear in the same cycle
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_set;

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) irq_st_q <= 2'h0;
    else irq_st_q <= irq_st_d;
  end

  // =====================================================================
  // Read data
  wire [15:0] stat_word = {10'h000, rtc_keep_q, pwr_q, sup_en, emerg_q, irq_st_q[`CGP_IRQ_OSC_FAIL]};
  logic [15:0] rmux;

  // Unmapped and write-only offsets read as zero
  always_comb begin
    case (BUS_I.addr)
      `CGP_OFF_CLK_CTRL: rmux = ctrl_q;
      `CGP_OFF_PERIPH_DIS: rmux = pdis_q;
      `CGP_OFF_PROGRAMMABLE_FREQ_OUTPUT_DIV: rmux = programmable_freq_output_div_q;
      `CGP_OFF_STATUS: rmux = stat_word;
      `CGP_OFF_IRQ_STATUS: rmux = {14'h0, irq_st_q};
      `CGP_OFF_IRQ_ENABLE: rmux = {14'h0, irq_en_q};
      `CGP_OFF_PWR_CTRL: rmux = {15'h0, rtc_keep_q};
      default: rmux = 16'h0000;
    endcase
  end

  // =====================================================================
  // Output flops
  wire cpu_run = pwr_q == CGP_RUN;
  wire rtc_run = !clocks_stop || rtc_keep_q;
  wire [NUM_PERIPH-1:0] pen = ~pdis_q[NUM_PERIPH-1:0] & PERIPH_ACTIVE_I;

  // All outputs registered; data stands only the cycle after a read
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 16'h0000;
      MASTER_TICK_O <= 1'b0;
      CAN_TICK_O <= 1'b0;
      MASTER_CLOCK_O <= 1'b0;
      SYS_TICK_O <= 1'b0;
      CPU_TICK_O <= 1'b0;
      PERIPH_TICK_O <= '0;
      RTC_TICK_O <= 1'b0;
      FREQ_OUT_O <= 1'b0;
      EMERGENCY_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      RDATA_O <= BUS_I.rd ? rmux : 16'h0000;
      MASTER_TICK_O <= mc_tick;
      CAN_TICK_O <= mc_tick;
      if (mc_tick) MASTER_CLOCK_O <= !MASTER_CLOCK_O;
      SYS_TICK_O <= sys_tick;
      CPU_TICK_O <= sys_tick && cpu_run;
      PERIPH_TICK_O <= sys_tick ? pen : '0;
      RTC_TICK_O <= free_tick && rtc_run;
      FREQ_OUT_O <= programmable_freq_output_q;
      EMERGENCY_O <= emerg_q;
      IRQ_O <= |(irq_st_d & irq_en_q);
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_fail_seen;
    osc_fail;
  endsequence

  sequence s_emerg_out;
    ##1 emerg_q ##1 EMERGENCY_O;
  endsequence

  a_emerg_switch: assert property (s_fail_seen |-> s_emerg_out)
    else $error("emergency not entered after oscillator fail");
  a_fail_flag: assert property (osc_fail |=> irq_st_q[`CGP_IRQ_OSC_FAIL])
    else $error("fail flag not set");
  a_flag_sticky: assert property (irq_st_q[0] && !clr_fail |=> irq_st_q[0])
    else $error("fail flag dropped without clear");
  a_no_sup_off: assert property (!sup_en |-> !osc_fail)
    else $error("supervisor fired while disabled");
  a_emerg_rate: assert property (emerg_q && mc_tick |-> free_tick)
    else $error("emergency tick not at basic rate");
  a_no_runt: assert property (osc_fail |-> !mc_tick ##1 (!mc_tick)[*2])
    else $error("short master period at switch");
  a_sleep_stop: assert property (clocks_stop |=> !SYS_TICK_O && !CPU_TICK_O && !MASTER_TICK_O)
    else $error("clock running in sleep");
  a_idle_cpu: assert property (pwr_q == CGP_IDLE |=> !CPU_TICK_O)
    else $error("CPU tick in idle");
  a_idle_sys: assert property (pwr_q == CGP_IDLE && sys_tick |=> SYS_TICK_O)
    else $error("system tick stopped in idle");
  a_sleep_wake: assert property (pwr_q == CGP_SLEEP && wake_sleep |=> pwr_q == CGP_RUN)
    else $error("sleep not left on wake");
  a_cpu_sys_eq: assert property (CPU_TICK_O |-> SYS_TICK_O)
    else $error("CPU and system clock differ");
  a_half_rate: assert property (ctrl_q.half && $past(ctrl_q.half) && sys_pre |-> !$past(sys_pre))
    else $error("two to one phase wrong");
  a_mode_instr: assert property (pwr_q == CGP_RUN && pwr_d != CGP_RUN |-> |INSTR_I)
    else $error("saving mode without instruction");

  // Output side checks on the registered ticks, and the emergency clear with PLL off
  a_can_copy: assert property (CAN_TICK_O == MASTER_TICK_O)
    else $error("CAN tick differs from master tick");
  a_mclk_toggle: assert property (MASTER_TICK_O |-> MASTER_CLOCK_O != $past(MASTER_CLOCK_O))
    else $error("master clock output did not toggle");
  a_periph_off: assert property (sys_tick && pdis_q[0] |=> !PERIPH_TICK_O[0])
    else $error("disabled peripheral still clocked");
  a_emerg_clear: assert property (!pll_on |=> !emerg_q)
    else $error("emergency held with PLL off");
  a_rtc_gate: assert property (clocks_stop && !rtc_keep_q |=> !RTC_TICK_O)
    else $error("real-time tick running in sleep");

endmodule

/* cgp_defs.svh */
// Constants for the clock generation, oscillator supervision and power block
// Operation
// - CPU and system clock: master 1:1 or 2:1
// - Master from PLL multiply or prescaler divide
// - PLL runs free in bypass modes
// - Oscillator loss: interrupt, switch to PLL
// - Emergency clock at PLL basic frequency
// - PLL off disables oscillator supervisor
// - Strap at reset release disables supervisor
// - Master clock is reference, CAN, output
// - Idle stops CPU, peripherals keep running
// - Sleep/power-down stop all, RTC optional
// - External interrupt ends sleep
// - Power modes entered by instruction only
// - Inactive logic gated; CPU clock slowable
// - Each peripheral individually disabled/enabled
// - Programmable frequency output pin
// - RTC cyclic wake-up ends sleep
`ifndef CGP_DEFS_SVH
`define CGP_DEFS_SVH

// =====================================================================
// Register offsets (word index on the register port)
`define CGP_ADDR_W 4
`define CGP_OFF_CLK_CTRL 4'h0
`define CGP_OFF_PERIPH_DIS 4'h1
`define CGP_OFF_PROGRAMMABLE_FREQ_OUTPUT_DIV 4'h2
`define CGP_OFF_STATUS 4'h3
`define CGP_OFF_IRQ_STATUS 4'h4
`define CGP_OFF_IRQ_CLEAR 4'h5
`define CGP_OFF_IRQ_ENABLE 4'h6
`define CGP_OFF_PWR_CTRL 4'h7

// =====================================================================
// Field positions
`define CGP_IRQ_OSC_FAIL 0
`define CGP_IRQ_WAKE 1
`define CGP_PWR_RTC_KEEP 0

// =====================================================================
// Reset values
`define CGP_RST_CLK_CTRL 16'h0001
`define CGP_RST_PERIPH_DIS 16'h0000
`define CGP_RST_PROGRAMMABLE_FREQ_OUTPUT_DIV 16'h0000
`define CGP_RST_IRQ_ENABLE 2'h0
`define CGP_RST_PWR_CTRL 1'h0

// =====================================================================
// Timing counts in CLOCK_I cycles or PLL basic ticks
`define CGP_PLL_FREE_DIV 16
`define CGP_OSC_MISS_LIMIT 4

`endif

/* cgp_osc_model.sv */
// Oscillator source and reset strap model at the far side of the clock block
`timescale 1ns/1ns

module cgp_osc_model (
  // Reference clock
  input wire logic clk_i,
  // Bench controls
  input wire logic run_i,
  input wire logic strap_low_i,
  // Pins
  output logic osc_o,
  output logic ext_access_select_n_o,
  output logic read_strobe_n_o
);
  logic half_q = 1'b0;
  logic osc_q = 1'b0;

  // =====================================================================
  // Oscillator: one rising edge every 4 clocks; a dead crystal holds its level
  always @(posedge clk_i) begin
    if (run_i) begin
      half_q <= ~half_q;
      if (half_q) begin
        osc_q <= ~osc_q;
      end
    end
  end
  assign osc_o = osc_q;

  // Straps: both lines pulled low to switch the supervisor off at reset
  assign ext_access_select_n_o = ~strap_low_i;
  assign read_strobe_n_o = ~strap_low_i;
endmodule

/* cgp_pkg.sv */
// Types shared by the clock generation and power block
package cgp_pkg;

  // Master clock source selection
  typedef enum logic [1:0] {CGP_SRC_PLL, CGP_SRC_DIRECT, CGP_SRC_PRESC, CGP_SRC_RSVD} cgp_src_type;

  // Power state of the device
  typedef enum logic [1:0] {CGP_RUN, CGP_IDLE, CGP_SLEEP, CGP_PWRDN} cgp_pwr_type;

  // Clock control register layout
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] cpu_slow;
    logic [3:0] presc;
    logic [1:0] mult;
    cgp_src_type src;
    logic half;
    logic pll_on;
  } cgp_clk_ctrl_type;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cgp_bus_req_type;

  // Power mode requests raised by CPU instructions
  typedef struct packed {
    logic idle;
    logic sleep;
    logic pwrdn;
  } cgp_instr_type;

endpackage

/* test_clock_gen_osc_watchdog_power.sv */
// Self-checking testbench for the clock generation and power block
`timescale 1ns/1ns

module test_clock_gen_osc_watchdog_power import cgp_pkg::*; ();
  logic clk;
  logic rst_n;
  cgp_bus_req_type bus;
  cgp_instr_type instr;
  logic [15:0] rdata;
  logic osc, ea_n, rd_n, osc_run, strap_low, ext_irq, rtc_wake;
  logic [7:0] active;
  logic mst, can, mclk, sys, cpu, rtc, fo, emerg, irq;
  logic [7:0] ptick;
  int miscompares = 0;
  int total_checks = 0;
  int n_mst, n_can, n_sys, n_cpu, n_p0, n_p1, n_p2, n_rtc, n_fo, n_mc;
  logic fo_prev, mc_prev;

  // =====================================================================
  // Clock and instances; shortened counts keep the run brief
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  cgp_osc_model osc_src (.clk_i(clk), .run_i(osc_run), .strap_low_i(strap_low), .osc_o(osc),
    .ext_access_select_n_o(ea_n), .read_strobe_n_o(rd_n));
  cgp_clock_power #(.NUM_PERIPH(8), .PLL_FREE_DIV(8), .OSC_MISS_LIMIT(2)) dut (.CLOCK_I(clk),
    .RESETN_I(rst_n), .BUS_I(bus), .RDATA_O(rdata), .OSC_PIN_I(osc), .EXT_ACCESS_SELECT_N_I(ea_n),
    .READ_STROBE_N_I(rd_n), .INSTR_I(instr), .EXT_IRQ_I(ext_irq), .RTC_WAKE_I(rtc_wake),
    .PERIPH_ACTIVE_I(active), .MASTER_TICK_O(mst), .CAN_TICK_O(can), .MASTER_CLOCK_O(mclk),
    .SYS_TICK_O(sys), .CPU_TICK_O(cpu), .PERIPH_TICK_O(ptick), .RTC_TICK_O(rtc), .FREQ_OUT_O(fo),
    .EMERGENCY_O(emerg), .IRQ_O(irq));

  // =====================================================================
  // Reporting
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Bus and stimulus tasks, all changes right after a rising edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // One-cycle pulse on an instruction or wake line
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: instr.idle <= 1'b1;
      1: instr.sleep <= 1'b1;
      2: instr.pwrdn <= 1'b1;
      3: ext_irq <= 1'b1;
      default: rtc_wake <= 1'b1;
    endcase
    @(posedge clk);
    instr <= '0;
    ext_irq <= 1'b0;
    rtc_wake <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Settle, then count pulses on every tick output (peripheral ticks 0 to 2 only) over a window
  task automatic count(input int n);
    {n_mst, n_can, n_sys, n_cpu, n_p0, n_p1, n_p2, n_rtc, n_fo, n_mc} = '0;
    repeat (16) @(posedge clk);
    #1;
    fo_prev = fo;
    mc_prev = mclk;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_mst += mst;
      n_can += can;
      n_sys += sys;
      n_cpu += cpu;
      n_p0 += ptick[0];
      n_p1 += ptick[1];
      n_p2 += ptick[2];
      n_rtc += rtc;
      n_fo += (fo !== fo_prev);
      n_mc += (mclk !== mc_prev);
      fo_prev = fo;
      mc_prev = mclk;
    end
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    bus = '0;
    instr = '0;
    {osc_run, strap_low, ext_irq, rtc_wake} = 4'b1000;
    active = 8'h03;
    do_reset();
    // Reset values, write-only and unmapped places
    rdc(4'h0, 16'h0001);
    rdc(4'h1, 16'h0000);
    rdc(4'h2, 16'h0000);
    rdc(4'h3, 16'h0004);
    rdc(4'h6, 16'h0000);
    rdc(4'h7, 16'h0000);
    rdc(4'h5, 16'h0000);
    rdc(4'hF, 16'h0000);
    $display("test reset values done");
    // Direct drive: one master tick per oscillator edge, PLL still free
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0001);
    wr(4'h0, 16'h0005);
    rdc(4'h1, 16'h0001);
    count(64);
    chk(n_mst, 16);
    chk(n_can, 16);
    chk(n_mc, 16);
    chk(n_sys, 16);
    chk(n_cpu, 16);
    chk(n_p0, 0);
    chk(n_p1, 16);
    chk(n_p2, 0);
    chk(n_rtc, 8);
    chk(n_fo, 8);
    wr(4'h1, 16'h0000);
    count(64);
    chk(n_p0, 16);
    wr(4'h0, 16'h0007);
    count(64);
    chk(n_mst, 16);
    chk(n_sys, 8);
    chk(n_cpu, 8);
    wr(4'h0, 16'h00C9);
    count(128);
    chk(n_mst, 8);
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 16'h0001 | 16'(m << 4));
      count(64);
      chk(n_mst, 8 << m);
    end
    wr(4'h0, 16'h0431);
    count(64);
    chk(n_cpu, 32);
    $display("test clock ratios done");
    // Power modes: register writes do not enter them, instructions do
    wr(4'h0, 16'h0005);
    wr(4'h3, 16'hFFFF);
    rdc(4'h3, 16'h0004);
    pulse(0);
    rdc(4'h3, 16'h000C);
    count(64);
    chk(n_cpu, 0);
    chk(n_sys, 16);
    pulse(3);
    rdc(4'h3, 16'h0004);
    wr(4'h7, 16'h0001);
    pulse(1);
    rdc(4'h3, 16'h0034);
    count(64);
    chk(n_mst, 0);
    chk(n_sys, 0);
    chk(n_cpu, 0);
    chk(n_rtc, 8);
    pulse(4);
    rdc(4'h3, 16'h0024);
    rdc(4'h4, 16'h0002);
    wr(4'h6, 16'h0003);
    rdc(4'h6, 16'h0003);
    chk(irq, 1'b1);
    wr(4'h5, 16'h0002);
    rdc(4'h4, 16'h0000);
    chk(irq, 1'b0);
    wr(4'h7, 16'h0000);
    pulse(1);
    count(64);
    chk(n_mst, 0);
    chk(n_p1, 0);
    chk(n_rtc, 0);
    chk(n_fo, 0);
    pulse(3);
    rdc(4'h3, 16'h0004);
    wr(4'h5, 16'h0002);
    $display("test power modes done");
    // Oscillator loss in direct drive
    @(posedge clk);
    osc_run <= 1'b0;
    for (int i = 0; i <= 300; i++) begin
      @(posedge clk);
      if (emerg === 1'b1) begin
        break;
      end
      if (i == 300) begin
        miscompares++;
        report_and_stop();
      end
    end
    rdc(4'h4, 16'h0001);
    rdc(4'h3, 16'h0007);
    chk(irq, 1'b1);
    count(64);
    chk(n_mst, 8);
    chk(n_mc, 8);
    @(posedge clk);
    osc_run <= 1'b1;
    repeat (32) @(posedge clk);
    rdc(4'h4, 16'h0001);
    wr(4'h5, 16'h0001);
    repeat (8) @(posedge clk);
    rdc(4'h4, 16'h0000);
    chk({emerg, irq}, 2'b00);
    // PLL off: supervisor silent
    wr(4'h0, 16'h0004);
    @(posedge clk);
    osc_run <= 1'b0;
    count(64);
    chk(n_rtc, 0);
    rdc(4'h4, 16'h0000);
    chk(emerg, 1'b0);
    osc_run <= 1'b1;
    $display("test oscillator supervisor done");
    // Power down leaves only by reset; strap then disables the supervisor
    wr(4'h0, 16'h0005);
    pulse(2);
    count(64);
    chk(n_mst, 0);
    pulse(3);
    rdc(4'h3, 16'h001C);
    strap_low <= 1'b1;
    do_reset();
    rdc(4'h3, 16'h0000);
    @(posedge clk);
    osc_run <= 1'b0;
    count(64);
    rdc(4'h4, 16'h0000);
    chk(emerg, 1'b0);
    $display("test power down and strap done");
    report_and_stop();
  end
endmodule
